//--- scl_top.sv
// smart card serial link core: registers, transmitter with retry, receiver with error signal
`timescale 1ns/1ps
module scl_top import scl_pkg::*; (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_line,
    output logic o_line_out,
    output logic o_line_oe,
    output logic o_pins_serial,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_tx_irq,
    output logic o_rx_irq,
    output logic o_error_irq
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] mode_q, mode_d, ctrl_q, ctrl_d, div_q, div_d;
    logic [7:0] txhold_q, txhold_d, rxhold_q, rxhold_d, rdata_q, rdata_d;
    logic transmit_end_flag_q, transmit_end_flag_d, tx_buffer_empty_flag_q, tx_buffer_empty_flag_d, rx_buffer_full_flag_q, rx_buffer_full_flag_d;
    logic per_q, per_d, overrun_error_flag_q, overrun_error_flag_d, ers_q, ers_d;
    logic txi_q, txi_d, rxi_q, rxi_d, eri_q, eri_d;
    logic sck_q, sck_d, sckoe_q, sckoe_d, oe_q, oe_d, ser_q, ser_d;
    logic line_s, line_p;
    logic basic, restart;
    logic [8:0] ratio, half;
    logic card_en, te, re;
    scl_tx_t tx_st_q, tx_st_d;
    logic [8:0] tph_q, tph_d;
    logic [3:0] tbit_q, tbit_d;
    logic [2:0] gcnt_q, gcnt_d;
    logic [9:0] tvec_q, tvec_d;
    logic terr_q, terr_d;
    logic tx_etu, tx_done, tx_err, tx_low;
    scl_rx_t rx_st_q, rx_st_d;
    logic [8:0] rph_q, rph_d;
    logic [3:0] rbit_q, rbit_d;
    logic [9:0] rvec_q, rvec_d;
    logic rx_mid, rx_start, rx_ok, rx_perr, rx_ovr, rx_store, rx_bad;
    logic [7:0] rx_byte;

    scl_brg_if brg_if ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] scl_reorder(input logic [7:0] b, input logic msb, input logic inv);
        logic [7:0] r;
        r = inv ? ~b : b;
        if (msb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = inv ? ~b[7 - i] : b[7 - i];
            end
        end
        return r;
    endfunction : scl_reorder

    // builds {parity, data, start} in line order, bit 0 sent first
    function automatic logic [9:0] scl_frame(input logic [7:0] b, input logic [7:0] m);
        logic [7:0] d;
        d = scl_reorder(b, m[MODE_MSB_FIRST], m[MODE_INVERT]);
        return {^d ^ m[MODE_PAR_ODD], d, 1'b0};
    endfunction : scl_frame

    // ------------------------------------------------------------
    // line input and bit-rate generator
    // ------------------------------------------------------------
    scl_sync u_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async(i_line),
        .o_sync(line_s)
    );

    scl_brg u_brg (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .brg(brg_if.gen)
    );

    assign brg_if.divisor = div_q;
    assign brg_if.restart = restart;

    always_comb begin
        case (mode_q[MODE_SEL_HI:MODE_SEL_LO])
            2'h0: ratio = RATIO_0;
            2'h1: ratio = RATIO_1;
            2'h2: ratio = RATIO_2;
            default: ratio = RATIO_3;
        endcase
        half = {1'b0, ratio[8:1]};
        card_en = mode_q[MODE_CARD_EN];
        te = ctrl_q[CTRL_TE];
        re = ctrl_q[CTRL_RE];
        rx_start = re && card_en && line_p && !line_s && (rx_st_q == RX_IDLE);
        // while the transmitter is not idle it owns the bit timing
        restart = rx_start && (tx_st_q == TX_IDLE);
        // basic clock edge is the rising edge of the card clock
        basic = brg_if.tick & ~sck_q & ~restart;
        tx_etu = basic && (tph_q == ratio - 9'h001);
        rx_mid = basic && (rph_q == half - 9'h001);
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    always_comb begin
        tx_st_d = tx_st_q;
        tph_d = tph_q;
        tbit_d = tbit_q;
        gcnt_d = gcnt_q;
        tvec_d = tvec_q;
        terr_d = terr_q;
        tx_done = 1'b0;
        tx_err = 1'b0;
        tx_low = 1'b0;
        if (basic) begin
            tph_d = tx_etu ? 9'h000 : tph_q + 9'h001;
        end
        case (tx_st_q)
            TX_IDLE: begin
                if (te && card_en && !tx_buffer_empty_flag_q) begin
                    tvec_d = scl_frame(txhold_q, mode_q);
                    tph_d = 9'h000;
                    tbit_d = 4'h0;
                    tx_st_d = TX_FRAME;
                end
            end
            TX_FRAME: begin
                tx_low = ~tvec_q[tbit_q];
                if (tx_etu) begin
                    if (tbit_q == FRAME_BITS - 4'h1) begin
                        tx_st_d = TX_GUARD;
                        gcnt_d = 3'h0;
                        terr_d = 1'b0;
                    end else begin
                        tbit_d = tbit_q + 4'h1;
                    end
                end
            end
            TX_GUARD: begin
                if (tx_etu) begin
                    gcnt_d = gcnt_q + 3'h1;
                    // card's error signal spans 10.5..11.5 etu; look at 11.0
                    if (gcnt_q == 3'h0 && !line_s) begin
                        terr_d = 1'b1;
                        tx_err = 1'b1;
                    end
                    if (!terr_q && gcnt_q == GUARD_ETU - 3'h1) begin
                        tx_done = 1'b1;
                        tx_st_d = TX_IDLE;
                    end else if (terr_q && gcnt_q == RETRY_ETU - 3'h1) begin
                        tvec_d = scl_frame(txhold_q, mode_q);
                        tbit_d = 4'h0;
                        tx_st_d = TX_FRAME;
                    end
                end
            end
            default: tx_st_d = TX_IDLE;
        endcase
        if (!te || !card_en) begin
            tx_st_d = TX_IDLE;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_st_q <= TX_IDLE;
            tph_q <= 9'h000;
            tbit_q <= 4'h0;
            gcnt_q <= 3'h0;
            tvec_q <= 10'h3ff;
            terr_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            tph_q <= tph_d;
            tbit_q <= tbit_d;
            gcnt_q <= gcnt_d;
            tvec_q <= tvec_d;
            terr_q <= terr_d;
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    always_comb begin
        rx_st_d = rx_st_q;
        rph_d = rph_q;
        rbit_d = rbit_q;
        rvec_d = rvec_q;
        rx_ok = 1'b0;
        rx_perr = 1'b0;
        rx_ovr = 1'b0;
        rx_store = 1'b0;
        rx_bad = ^rvec_q[8:1] ^ line_s ^ mode_q[MODE_PAR_ODD];
        rx_byte = scl_reorder(rvec_q[8:1], mode_q[MODE_MSB_FIRST], mode_q[MODE_INVERT]);
        if (basic) begin
            rph_d = (rph_q == ratio - 9'h001) ? 9'h000 : rph_q + 9'h001;
        end
        case (rx_st_q)
            RX_IDLE: begin
                if (rx_start) begin
                    rph_d = 9'h000;
                    rbit_d = 4'h0;
                    rx_st_d = RX_FRAME;
                end
            end
            RX_FRAME: begin
                if (rx_mid) begin
                    rvec_d[rbit_q] = line_s;
                    if (rbit_q == 4'h0 && line_s) begin
                        rx_st_d = RX_IDLE;
                    end else if (rbit_q == FRAME_BITS - 4'h1) begin
                        rx_ovr = rx_buffer_full_flag_q;
                        rx_store = !rx_buffer_full_flag_q;
                        rx_perr = rx_bad && !rx_buffer_full_flag_q;
                        rx_ok = !rx_bad && !rx_buffer_full_flag_q;
                        rx_st_d = rx_bad ? RX_ERRGAP : RX_IDLE;
                    end else begin
                        rbit_d = rbit_q + 4'h1;
                    end
                end
            end
            RX_ERRGAP: begin
                if (rx_mid) begin
                    rx_st_d = RX_ERRDRV;
                end
            end
            RX_ERRDRV: begin
                if (rx_mid) begin
                    rx_st_d = RX_IDLE;
                end
            end
            default: rx_st_d = RX_IDLE;
        endcase
        if (!re || !card_en) begin
            rx_st_d = RX_IDLE;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_st_q <= RX_IDLE;
            rph_q <= 9'h000;
            rbit_q <= 4'h0;
            rvec_q <= 10'h000;
            line_p <= 1'b1;
        end else begin
            rx_st_q <= rx_st_d;
            rph_q <= rph_d;
            rbit_q <= rbit_d;
            rvec_q <= rvec_d;
            line_p <= line_s;
        end
    end

    // ------------------------------------------------------------
    // registers, flags, requests and pins
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        div_d = div_q;
        txhold_d = txhold_q;
        rxhold_d = rxhold_q;
        transmit_end_flag_d = transmit_end_flag_q;
        tx_buffer_empty_flag_d = tx_buffer_empty_flag_q;
        rx_buffer_full_flag_d = rx_buffer_full_flag_q;
        per_d = per_q;
        overrun_error_flag_d = overrun_error_flag_q;
        ers_d = ers_q;
        rdata_d = 8'h00;
        if (i_wr) begin
            case (i_addr)
                ADR_MODE: mode_d = i_wdata;
                ADR_CTRL: ctrl_d = i_wdata;
                ADR_DIV: div_d = i_wdata;
                ADR_STAT: begin
                    // write zero to clear; ones leave the flag alone
                    rx_buffer_full_flag_d = rx_buffer_full_flag_q & i_wdata[STAT_RX_BUFFER_FULL_FLAG];
                    per_d = per_q & i_wdata[STAT_PER];
                    overrun_error_flag_d = overrun_error_flag_q & i_wdata[STAT_OVERRUN_ERROR_FLAG];
                    ers_d = ers_q & i_wdata[STAT_ERS];
                end
                ADR_TXD: begin
                    txhold_d = i_wdata;
                    tx_buffer_empty_flag_d = 1'b0;
                    transmit_end_flag_d = 1'b0;
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                ADR_MODE: rdata_d = mode_q;
                ADR_CTRL: rdata_d = ctrl_q;
                ADR_DIV: rdata_d = div_q;
                ADR_STAT: rdata_d = {2'h0, ers_q, overrun_error_flag_q, per_q, rx_buffer_full_flag_q, tx_buffer_empty_flag_q, transmit_end_flag_q};
                ADR_TXD: rdata_d = txhold_q;
                ADR_RXD: begin
                    rdata_d = rxhold_q;
                    rx_buffer_full_flag_d = 1'b0;
                end
                default: rdata_d = 8'h00;
            endcase
        end
        // hardware sets win over a same-cycle clear
        if (tx_done) begin
            transmit_end_flag_d = 1'b1;
            tx_buffer_empty_flag_d = 1'b1;
        end
        if (tx_err) begin
            ers_d = 1'b1;
        end
        if (rx_store) begin
            rxhold_d = rx_byte;
        end
        if (rx_ok) begin
            rx_buffer_full_flag_d = 1'b1;
        end
        if (rx_perr) begin
            per_d = 1'b1;
        end
        if (rx_ovr) begin
            overrun_error_flag_d = 1'b1;
        end
        txi_d = ctrl_q[CTRL_TIE] & transmit_end_flag_q & (tx_st_q == TX_IDLE);
        rxi_d = ctrl_q[CTRL_RIE] & rx_buffer_full_flag_q & ~per_q & ~overrun_error_flag_q;
        eri_d = ctrl_q[CTRL_RIE] & (ers_q | per_q | overrun_error_flag_q);
        // restart trades a short clock phase for exact bit alignment
        sck_d = restart ? 1'b0 : (brg_if.tick ? ~sck_q : sck_q);
        sckoe_d = card_en & ctrl_q[CTRL_CKE];
        ser_d = card_en;
        oe_d = card_en & (tx_low | (rx_st_q == RX_ERRDRV));
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q <= MODE_RST;
            ctrl_q <= CTRL_RST;
            div_q <= DIV_RST;
            txhold_q <= 8'h00;
            rxhold_q <= 8'h00;
            rdata_q <= 8'h00;
            transmit_end_flag_q <= 1'b1;
            tx_buffer_empty_flag_q <= 1'b1;
            rx_buffer_full_flag_q <= 1'b0;
            per_q <= 1'b0;
            overrun_error_flag_q <= 1'b0;
            ers_q <= 1'b0;
            txi_q <= 1'b0;
            rxi_q <= 1'b0;
            eri_q <= 1'b0;
            sck_q <= 1'b0;
            sckoe_q <= 1'b0;
            ser_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            div_q <= div_d;
            txhold_q <= txhold_d;
            rxhold_q <= rxhold_d;
            rdata_q <= rdata_d;
            transmit_end_flag_q <= transmit_end_flag_d;
            tx_buffer_empty_flag_q <= tx_buffer_empty_flag_d;
            rx_buffer_full_flag_q <= rx_buffer_full_flag_d;
            per_q <= per_d;
            overrun_error_flag_q <= overrun_error_flag_d;
            ers_q <= ers_d;
            txi_q <= txi_d;
            rxi_q <= rxi_d;
            eri_q <= eri_d;
            sck_q <= sck_d;
            sckoe_q <= sckoe_d;
            ser_q <= ser_d;
            oe_q <= oe_d;
        end
    end

    // the line is open-drain: only ever pulled low, released otherwise
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_line_out <= 1'b0;
        end else begin
            o_line_out <= 1'b0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_line_oe = oe_q;
    assign o_pins_serial = ser_q;
    assign o_sck = sck_q;
    assign o_sck_oe = sckoe_q;
    assign o_tx_irq = txi_q;
    assign o_rx_irq = rxi_q;
    assign o_error_irq = eri_q;
endmodule : scl_top

//--- scl_pkg.sv
// constants, field layout and state types of the smart card serial link
package scl_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] ADR_MODE = 3'h0;
    localparam logic [2:0] ADR_CTRL = 3'h1;
    localparam logic [2:0] ADR_DIV = 3'h2;
    localparam logic [2:0] ADR_STAT = 3'h3;
    localparam logic [2:0] ADR_TXD = 3'h4;
    localparam logic [2:0] ADR_RXD = 3'h5;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_SEL_LO = 0;
    localparam int MODE_SEL_HI = 1;
    localparam int MODE_PAR_ODD = 2;
    localparam int MODE_CARD_EN = 3;
    localparam int MODE_MSB_FIRST = 4;
    localparam int MODE_INVERT = 5;
    localparam int CTRL_TE = 0;
    localparam int CTRL_RE = 1;
    localparam int CTRL_TIE = 2;
    localparam int CTRL_RIE = 3;
    localparam int CTRL_CKE = 4;
    localparam int STAT_TRANSMIT_END_FLAG = 0;
    localparam int STAT_TX_BUFFER_EMPTY_FLAG = 1;
    localparam int STAT_RX_BUFFER_FULL_FLAG = 2;
    localparam int STAT_PER = 3;
    localparam int STAT_OVERRUN_ERROR_FLAG = 4;
    localparam int STAT_ERS = 5;
    // ------------------------------------------------------------
    // reset values and frame timing
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [8:0] RATIO_0 = 9'h020;
    localparam logic [8:0] RATIO_1 = 9'h040;
    localparam logic [8:0] RATIO_2 = 9'h174;
    localparam logic [8:0] RATIO_3 = 9'h100;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [2:0] GUARD_ETU = 3'h2;
    localparam logic [2:0] RETRY_ETU = 3'h4;
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_GUARD} scl_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_ERRGAP, RX_ERRDRV} scl_rx_t;
endpackage : scl_pkg

//--- scl_brg_if.sv
// link between the core and its bit-rate generator
`timescale 1ns/1ps
interface scl_brg_if;
    logic [7:0] divisor;
    logic restart;
    logic tick;
    modport gen (input divisor, input restart, output tick);
    modport user (output divisor, output restart, input tick);
endinterface : scl_brg_if

//--- scl_sync.sv
// two-stage synchroniser for a pin input
`timescale 1ns/1ps
module scl_sync (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;
    logic meta_d;
    logic sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // reset to the idle (pulled-up) level of the line
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta_q <= meta_d;
            o_sync <= sync_d;
        end
    end
endmodule : scl_sync

//--- scl_brg.sv
// bit-rate generator: one tick per divisor+1 system clocks
`timescale 1ns/1ps
module scl_brg (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    scl_brg_if.gen brg
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        brg.tick = 1'b0;
        cnt_d = cnt_q + 8'h01;
        if (brg.restart) begin
            cnt_d = 8'h00;
        end else if (cnt_q >= brg.divisor) begin
            cnt_d = 8'h00;
            brg.tick = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : scl_brg

//--- scl_monitor.sv
// port assertions for the smart card serial link
`timescale 1ns/1ps
module scl_monitor import scl_pkg::*; (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic o_line_out,
    input wire logic o_line_oe,
    input wire logic o_pins_serial,
    input wire logic o_sck,
    input wire logic o_sck_oe,
    input wire logic o_tx_irq,
    input wire logic o_rx_irq,
    input wire logic o_error_irq
);
    // ------
    // checks
    // ------
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    open_drain_a: assert property (o_line_out == 1'b0)
        else $error("line drive value not low");
    line_owner_a: assert property (o_line_oe |-> o_pins_serial || $past(o_pins_serial))
        else $error("line pulled outside card mode");
    clock_owner_a: assert property (o_sck_oe |-> o_pins_serial)
        else $error("card clock driven outside card mode");
    // a divisor of 255 still toggles the clock well inside this bound
    clock_runs_a: assert property (o_sck_oe |-> ##[1:600] $changed(o_sck))
        else $error("card clock stalled");
    pull_width_a: assert property ($rose(o_line_oe) |-> o_line_oe [*8])
        else $error("line pulse shorter than a bit");
    rx_req_clear_a: assert property (i_rd && i_addr == ADR_RXD |-> ##4 !o_rx_irq)
        else $error("rx request stays after data read");
    tx_req_clear_a: assert property (i_wr && i_addr == ADR_TXD |-> ##4 !o_tx_irq)
        else $error("tx request stays after data write");
    req_excl_a: assert property (o_error_irq |-> !o_rx_irq)
        else $error("rx request beside error request");
endmodule : scl_monitor

bind scl_top scl_monitor mon (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_pins_serial(o_pins_serial), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_error_irq(o_error_irq));

//--- scl_card_model.sv
// behavioural card on the pulled-up data line
`timescale 1ns/1ps
module scl_card_model (
    input wire logic i_clock,
    input wire logic i_line,
    output logic o_pull_low
);
    int etu = 64;
    int frames = 0;
    bit nack = 0;
    bit busy = 0;
    bit saw_err = 0;
    logic [8:0] rx_bits = 9'h000;
    initial o_pull_low = 1'b0;
    // ------
    // receive a frame, answer with an error signal on request
    // ------
    always @(negedge i_line) begin
        if (!busy) begin
            busy = 1;
            repeat (etu / 2) @(posedge i_clock);
            for (int i = 0; i < 9; i++) begin
                repeat (etu) @(posedge i_clock);
                rx_bits[i] = i_line;
            end
            if (nack) begin
                repeat (etu) @(posedge i_clock);
                o_pull_low <= 1'b1;
                repeat (etu) @(posedge i_clock);
                o_pull_low <= 1'b0;
                nack = 0;
            end
            frames++;
            busy = 0;
        end
    end
    // ------
    // send one frame; the line goes back to the pull-up after parity
    // ------
    task automatic send(input logic [7:0] b, input bit bad);
        logic [9:0] f;
        f = {(^b) ^ bad, b, 1'b0};
        busy = 1;
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clock);
            o_pull_low <= !f[i];
            repeat (etu - 1) @(posedge i_clock);
        end
        @(posedge i_clock);
        o_pull_low <= 1'b0;
        repeat (etu) @(posedge i_clock);
        saw_err = !i_line;
        repeat (etu) @(posedge i_clock);
        busy = 0;
    endtask : send
endmodule : scl_card_model

//--- tb_top.sv
// self-checking bench for the smart card serial link
`timescale 1ns/1ps
module tb_top import scl_pkg::*; ();
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_line_out, o_line_oe, o_pins_serial, o_sck, o_sck_oe, o_tx_irq, o_rx_irq, o_error_irq, card_low;
    logic [8:0] ratio [4] = '{RATIO_0, RATIO_1, RATIO_2, RATIO_3};
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    wire line_lvl = !o_line_oe && !card_low;
    scl_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_line(line_lvl), .o_line_out(o_line_out), .o_line_oe(o_line_oe),
        .o_pins_serial(o_pins_serial), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_tx_irq(o_tx_irq),
        .o_rx_irq(o_rx_irq), .o_error_irq(o_error_irq));
    scl_card_model card (.i_clock(i_clock), .i_line(line_lvl), .o_pull_low(card_low));
    initial forever #2.5 i_clock = ~i_clock;
    // ------
    // tasks
    // ------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp);
    endtask : rd
    task automatic wait_frames;
        int t;
        t = card.frames + 1;
        for (int n = 0; n < 20000 && card.frames < t; n++) @(posedge i_clock);
        check(card.frames >= t, 1'b1);
    endtask : wait_frames
    task automatic tx_byte(input logic [7:0] b, input bit inv, input bit err);
        int n;
        logic [8:0] exp;
        for (int i = 0; i < 8; i++) exp[i] = inv ? !b[7-i] : b[i];
        exp[8] = (^exp[7:0]) ^ inv;
        card.nack = err;
        wr(ADR_TXD, b);
        rd(ADR_STAT, 8'h00);
        wait_frames();
        if (err) begin
            rd(ADR_STAT, 8'h20);
            check(o_error_irq, 1'b1);
            wait_frames();
        end
        // the request may only come after the guard time
        for (n = 0; n < 3000 && o_tx_irq !== 1'b1; n++) @(posedge i_clock);
        check(n >= 64, 1'b1);
        check(o_tx_irq, 1'b1);
        check(card.rx_bits, exp);
        rd(ADR_STAT, err ? 8'h23 : 8'h03);
    endtask : tx_byte
    task automatic give_verdict;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end
    // ------
    // sequence
    // ------
    initial begin
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd(ADR_STAT, 8'h03);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        wr(ADR_MODE, 8'h08);
        wr(ADR_DIV, 8'h00);
        wr(ADR_CTRL, 8'h10);
        repeat (70) @(posedge i_clock);
        check(o_pins_serial, 1'b1);
        check(o_line_oe, 1'b0);
        check(o_sck_oe, 1'b1);
        wr(ADR_CTRL, 8'h1d);
        tx_byte(8'h3b, 1'b0, 1'b0);
        tx_byte(8'ha5, 1'b0, 1'b1);
        wr(ADR_STAT, 8'h1f);
        rd(ADR_STAT, 8'h03);
        wr(ADR_CTRL, 8'h10);
        wr(ADR_MODE, 8'h3c);
        wr(ADR_CTRL, 8'h1d);
        tx_byte(8'h3f, 1'b1, 1'b0);
        wr(ADR_CTRL, 8'h10);
        wr(ADR_CTRL, 8'h1a);
        for (int r = 0; r < 4; r++) begin
            card.etu = 2 * ratio[r];
            wr(ADR_MODE, 8'h08 | 8'(r));
            card.send(8'h50 + 8'(r), 1'b0);
            check(card.saw_err, 1'b0);
            check(o_rx_irq, 1'b1);
            rd(ADR_STAT, 8'h07);
            rd(ADR_RXD, 8'h50 + 8'(r));
        end
        card.etu = 64;
        wr(ADR_MODE, 8'h08);
        card.send(8'hc3, 1'b1);
        check(card.saw_err, 1'b1);
        rd(ADR_STAT, 8'h0b);
        check(o_error_irq, 1'b1);
        check(o_rx_irq, 1'b0);
        rd(ADR_RXD, 8'hc3);
        wr(ADR_STAT, 8'h37);
        card.send(8'h11, 1'b0);
        card.send(8'h22, 1'b0);
        rd(ADR_STAT, 8'h17);
        check(o_rx_irq, 1'b0);
        rd(ADR_RXD, 8'h11);
        wr(ADR_STAT, 8'h2f);
        rd(ADR_STAT, 8'h03);
        give_verdict();
    end
endmodule : tb_top
